// *** verilog/hub_cfg_pkg.sv ***
// Shared constants and helpers for the receive-port configuration hub
`default_nettype none
package hub_cfg_pkg;
    localparam int NUM_PORTS = 4;
    // Register offsets, one byte each
    localparam logic [7:0] OFS_RX_DISABLE = 8'h0C;
    localparam logic [7:0] OFS_FWD_CTL = 8'h20;
    localparam logic [7:0] OFS_PAGE_SEL = 8'h4C;
    localparam logic [7:0] OFS_BC_RATE = 8'h58;
    localparam logic [7:0] OFS_RX_MODE = 8'h6D;
    localparam logic [7:0] OFS_DIRECT0 = 8'hF8;
    localparam logic [7:0] OFS_DIRECT3 = 8'hFB;
    // Reset values
    localparam logic [3:0] RST_RX_DISABLE = 4'h0;
    localparam logic [3:0] RST_FWD_CTL = 4'h0;
    localparam logic [7:0] RST_PAGE_SEL = 8'h01;
    localparam logic [7:0] RST_DIRECT = 8'h00;
    // Page select: write mask in [3:0], read port in [5:4]
    localparam logic [7:0] PAGE_SEL_MASK = 8'h3F;
    localparam int PAGE_RD_LSB = 4;
    // Direct address register: address in [7:1], enable in [0]
    localparam int DIRECT_EN_BIT = 0;
    localparam int DIRECT_ADDR_LSB = 1;
    localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h3D;
    // Receive mode codes
    localparam logic [1:0] MODE_CSI2 = 2'h0;
    localparam logic [1:0] RAW12_LOW_FREQ_MODE = 2'h1;
    localparam logic [1:0] RAW12_HIGH_FREQ_MODE = 2'h2;
    localparam logic [1:0] RAW_TEN_BIT_MODE = 2'h3;
    // Back-channel rate codes
    localparam logic [2:0] BC_RATE_2M5 = 3'h0;
    localparam logic [2:0] BC_RATE_10M = 3'h2;
    localparam logic [2:0] BC_RATE_50M = 3'h6;
    localparam logic [5:0] FRAME_BITS_CSI2 = 6'h28;
    localparam logic [5:0] FRAME_BITS_RAW = 6'h1C;
    // Timing
    localparam int CLK_HZ = 25_000_000;
    localparam int REF_GAP_US = 20;
    localparam int REF_GAP_CYC = (REF_GAP_US * CLK_HZ) / 1_000_000;
    localparam int REF_QUAL_US = 10;
    localparam int REF_QUAL_CYC = (REF_QUAL_US * CLK_HZ + 999_999) / 1_000_000;
    localparam logic [1:0] STRAP_SETTLE_CYC = 2'h3;

    function automatic logic [2:0] bc_default(input logic [1:0] m);
        return (m == MODE_CSI2) ? BC_RATE_50M : BC_RATE_2M5;
    endfunction

    function automatic logic [5:0] frame_bits(input logic [1:0] m);
        return (m == MODE_CSI2) ? FRAME_BITS_CSI2 : FRAME_BITS_RAW;
    endfunction
endpackage
`default_nettype wire

// *** verilog/mode_if.sv ***
// Strap capture signals between the register bank and the strap decoder
`default_nettype none
interface mode_if;
    logic [2:0] strapPin;
    logic [1:0] strapMode;
    logic strapValid;
    modport decoder (input strapPin, output strapMode, output strapValid);
    modport bank (output strapPin, input strapMode, input strapValid);
endinterface
`default_nettype wire

// *** verilog/strap_mode_decode.sv ***
// Mode strap synchroniser, decoder and one-shot capture after reset
`default_nettype none
module strap_mode_decode
    import hub_cfg_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Strap link to the bank
    mode_if.decoder modeBus
);
    logic [2:0] meta_q;
    logic [2:0] sync_q;
    logic [1:0] mode_q;
    logic [1:0] settle_q;
    logic caught_q;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            meta_q <= 3'h0;
            sync_q <= 3'h0;
        end else begin
            meta_q <= modeBus.strapPin;
            sync_q <= meta_q;
        end
    end

    // Upper and lower halves of the strap range select the same mode
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            mode_q <= MODE_CSI2;
        end else begin
            case (sync_q)
                3'h0, 3'h4: mode_q <= MODE_CSI2;
                3'h1, 3'h5: mode_q <= RAW12_LOW_FREQ_MODE;
                3'h2, 3'h6: mode_q <= RAW12_HIGH_FREQ_MODE;
                default: mode_q <= RAW_TEN_BIT_MODE;
            endcase
        end
    end

    // Capture once, after the pin has passed both sync stages
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            settle_q <= 2'h0;
            caught_q <= 1'b0;
        end else if (settle_q != STRAP_SETTLE_CYC) begin
            settle_q <= settle_q + 2'h1;
        end else begin
            caught_q <= 1'b1;
        end
    end

    assign modeBus.strapMode = mode_q;
    assign modeBus.strapValid = (settle_q == STRAP_SETTLE_CYC) && !caught_q;

    property p_strap_decode;
        @(posedge sys_clk) disable iff (!nrst)
        modeBus.strapValid |-> modeBus.strapMode == $past(modeBus.strapPin[1:0], 3);
    endproperty
    a_strap_decode: assert property (p_strap_decode) else $error("strap index decoded wrongly");
endmodule
`default_nettype wire

// *** verilog/hub_rx_port_config.sv ***
// I2C target with receive-port configuration registers, paging and clock select
`default_nettype none
// Overview of operation
// - Mode comes from strap or register write
// - CSI-2: 40-bit frame, 50 Mbps back channel
// - RAW modes: 28-bit frame, 2.5 Mbps
// - Strap index modulo four selects mode
// - Mode readable and writable at 0x6D[1:0]
// - Timers run from the 23-26 MHz reference
// - Start on backup oscillator until reference qualifies
// - 0x0C disables each receive input separately
// - Remote masters cannot write 0x0C
// - 0x4C selects the per-port register page
// - Remote accesses page their own port unless directly addressed
// - 0xF8-0xFB hold direct 7-bit port addresses
// - Direct addresses also reach shared registers
// - Forwarding at 0x20 off after reset
module hub_rx_port_config
    import hub_cfg_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // I2C target pins
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    // Origin of the current transaction
    input wire logic remoteAccess,
    input wire logic [1:0] remotePort,
    // Strap and reference detect pins
    input wire logic [2:0] modeStrapIdx,
    input wire logic refClkPresent,
    // Port configuration
    output logic [NUM_PORTS-1:0] rxPortDisable,
    output logic [NUM_PORTS-1:0] forwardEnable,
    output logic [2*NUM_PORTS-1:0] rxModeOut,
    output logic [3*NUM_PORTS-1:0] bcRateOut,
    output logic [6*NUM_PORTS-1:0] frameBitsOut,
    // Clock source
    output logic useRefClk,
    output logic backupOscOn
);
    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_ADDR_DONE, ST_ACK, ST_WDATA,
        ST_WDONE, ST_RDATA, ST_RDONE, ST_RACK
    } i2c_state_e;

    localparam logic [11:0] GAP_CNT = 12'(REF_GAP_CYC - 1);
    localparam logic [11:0] QUAL_CNT = 12'(REF_QUAL_CYC - 1);

    logic sclMeta_q, sclSync_q, sclPrev_q;
    logic sdaMeta_q, sdaSync_q, sdaPrev_q;
    logic refMeta_q, refSync_q;
    logic sclRise, sclFall, startDet, stopDet;
    i2c_state_e state_q;
    logic [2:0] bitCnt_q;
    logic [7:0] shift_q;
    logic [7:0] regPtr_q;
    logic isRead_q, ptrPhase_q, direct_q, remote_q, sdaOe_q;
    logic [1:0] directPort_q, remPort_q;
    logic [NUM_PORTS-1:0] rxDisable_q, fwdCtl_q;
    logic [7:0] pageSel_q;
    logic [7:0] directAddr_q [NUM_PORTS];
    logic [1:0] mode_q [NUM_PORTS];
    logic [2:0] bcRate_q [NUM_PORTS];
    logic [5:0] frame_q [NUM_PORTS];
    logic [NUM_PORTS-1:0] portHit, wrMask;
    logic hostHit, wrStrobe;
    logic [1:0] hitIdx, rdPort;
    logic [7:0] rdData;
    logic [11:0] refCnt_q;
    logic useRef_q;

    mode_if modeBus ();

    strap_mode_decode uDecode (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .modeBus(modeBus.decoder)
    );

    assign modeBus.strapPin = modeStrapIdx;

    // Pin synchronisers; edges come from the second and third stages, the first is never looked at
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            sclMeta_q <= 1'b1;
            sclSync_q <= 1'b1;
            sclPrev_q <= 1'b1;
            sdaMeta_q <= 1'b1;
            sdaSync_q <= 1'b1;
            sdaPrev_q <= 1'b1;
            refMeta_q <= 1'b0;
            refSync_q <= 1'b0;
        end else begin
            sclMeta_q <= sclIn;
            sclSync_q <= sclMeta_q;
            sclPrev_q <= sclSync_q;
            sdaMeta_q <= sdaIn;
            sdaSync_q <= sdaMeta_q;
            sdaPrev_q <= sdaSync_q;
            refMeta_q <= refClkPresent;
            refSync_q <= refMeta_q;
        end
    end

    assign sclRise = sclSync_q & ~sclPrev_q;
    assign sclFall = ~sclSync_q & sclPrev_q;
    assign startDet = sclSync_q & sclPrev_q & sdaPrev_q & ~sdaSync_q;
    assign stopDet = sclSync_q & sclPrev_q & ~sdaPrev_q & sdaSync_q;

    // Address match against the main and the direct port addresses
    assign hostHit = shift_q[7:1] == DEV_ADDR;
    for (genvar i = 0; i < NUM_PORTS; i++) begin : gHit
        assign portHit[i] = directAddr_q[i][DIRECT_EN_BIT] &&
            directAddr_q[i][7:DIRECT_ADDR_LSB] == shift_q[7:1];
    end

    always_comb begin
        hitIdx = 2'h0;
        for (int k = NUM_PORTS - 1; k >= 0; k--) begin
            if (portHit[k]) begin
                hitIdx = 2'(k);
            end
        end
    end

    // Page: direct address wins, then remote origin, then page register
    always_comb begin
        if (direct_q) begin
            wrMask = 4'h1 << directPort_q;
            rdPort = directPort_q;
        end else if (remote_q) begin
            wrMask = 4'h1 << remPort_q;
            rdPort = remPort_q;
        end else begin
            wrMask = pageSel_q[NUM_PORTS-1:0];
            rdPort = pageSel_q[PAGE_RD_LSB+:2];
        end
    end

    assign wrStrobe = (state_q == ST_WDONE) && sclFall && !ptrPhase_q;

    // Byte-wide registers, unused bits and offsets read as zero
    always_comb begin
        rdData = 8'h00;
        case (regPtr_q)
            OFS_RX_DISABLE: rdData = 8'(rxDisable_q);
            OFS_FWD_CTL: rdData = 8'(fwdCtl_q);
            OFS_PAGE_SEL: rdData = pageSel_q;
            OFS_BC_RATE: rdData = 8'(bcRate_q[rdPort]);
            OFS_RX_MODE: rdData = 8'(mode_q[rdPort]);
            default: begin
                if (regPtr_q >= OFS_DIRECT0 && regPtr_q <= OFS_DIRECT3) begin
                    rdData = directAddr_q[2'(regPtr_q - OFS_DIRECT0)];
                end
            end
        endcase
    end

    // I2C target sequencer
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= ST_IDLE;
            bitCnt_q <= 3'h0;
            shift_q <= 8'h00;
            isRead_q <= 1'b0;
            ptrPhase_q <= 1'b0;
            direct_q <= 1'b0;
            directPort_q <= 2'h0;
            remote_q <= 1'b0;
            remPort_q <= 2'h0;
            sdaOe_q <= 1'b0;
        end else if (startDet) begin
            state_q <= ST_ADDR;
            bitCnt_q <= 3'h0;
            sdaOe_q <= 1'b0;
        end else if (stopDet) begin
            state_q <= ST_IDLE;
            sdaOe_q <= 1'b0;
        end else begin
            case (state_q)
                ST_ADDR, ST_WDATA: begin
                    if (sclRise) begin
                        shift_q <= {shift_q[6:0], sdaSync_q};
                        bitCnt_q <= bitCnt_q + 3'h1;
                        if (bitCnt_q == 3'h7) begin
                            state_q <= (state_q == ST_ADDR) ? ST_ADDR_DONE : ST_WDONE;
                        end
                    end
                end
                ST_ADDR_DONE: begin
                    if (sclFall) begin
                        if (hostHit || |portHit) begin
                            sdaOe_q <= 1'b1;
                            state_q <= ST_ACK;
                            isRead_q <= shift_q[0];
                            direct_q <= !hostHit;
                            directPort_q <= hitIdx;
                            remote_q <= remoteAccess;
                            remPort_q <= remotePort;
                            if (!shift_q[0]) begin
                                ptrPhase_q <= 1'b1;
                            end
                        end else begin
                            state_q <= ST_IDLE;
                        end
                    end
                end
                ST_WDONE: begin
                    if (sclFall) begin
                        sdaOe_q <= 1'b1;
                        ptrPhase_q <= 1'b0;
                        state_q <= ST_ACK;
                    end
                end
                ST_ACK: begin
                    if (sclFall) begin
                        bitCnt_q <= 3'h0;
                        if (isRead_q) begin
                            shift_q <= rdData;
                            sdaOe_q <= ~rdData[7];
                            state_q <= ST_RDATA;
                        end else begin
                            sdaOe_q <= 1'b0;
                            state_q <= ST_WDATA;
                        end
                    end
                end
                ST_RDATA: begin
                    if (sclRise) begin
                        bitCnt_q <= bitCnt_q + 3'h1;
                        if (bitCnt_q == 3'h7) begin
                            state_q <= ST_RDONE;
                        end
                    end else if (sclFall && bitCnt_q != 3'h0) begin
                        sdaOe_q <= ~shift_q[6];
                        shift_q <= {shift_q[6:0], 1'b0};
                    end
                end
                ST_RDONE: begin
                    if (sclFall) begin
                        sdaOe_q <= 1'b0;
                        state_q <= ST_RACK;
                    end
                end
                ST_RACK: begin
                    if (sclRise) begin
                        state_q <= sdaSync_q ? ST_IDLE : ST_ACK;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Register pointer: first written byte loads it, each data byte steps it
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            regPtr_q <= 8'h00;
        end else if (state_q == ST_WDONE && sclFall) begin
            regPtr_q <= ptrPhase_q ? shift_q : regPtr_q + 8'h01;
        end else if (state_q == ST_ACK && sclFall && isRead_q) begin
            regPtr_q <= regPtr_q + 8'h01;
        end
    end

    // Shared registers
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rxDisable_q <= RST_RX_DISABLE;
            fwdCtl_q <= RST_FWD_CTL;
            pageSel_q <= RST_PAGE_SEL;
        end else if (wrStrobe) begin
            case (regPtr_q)
                OFS_RX_DISABLE: begin
                    if (!remote_q) begin
                        rxDisable_q <= shift_q[NUM_PORTS-1:0];
                    end
                end
                OFS_FWD_CTL: fwdCtl_q <= shift_q[NUM_PORTS-1:0];
                OFS_PAGE_SEL: begin
                    // A remote master works on its own page instead, or on the direct port's page when it used a direct address
                    if (!remote_q) begin
                        pageSel_q <= shift_q & PAGE_SEL_MASK;
                    end
                end
                default: ;
            endcase
        end
    end

    // Per-port registers and direct addresses
    for (genvar i = 0; i < NUM_PORTS; i++) begin : gPort
        always_ff @(posedge sys_clk or negedge nrst) begin
            if (!nrst) begin
                directAddr_q[i] <= RST_DIRECT;
            end else if (wrStrobe && regPtr_q == OFS_DIRECT0 + 8'(i)) begin
                directAddr_q[i] <= shift_q;
            end
        end

        // Changing the mode reloads the back-channel default for it
        always_ff @(posedge sys_clk or negedge nrst) begin
            if (!nrst) begin
                mode_q[i] <= MODE_CSI2;
                bcRate_q[i] <= BC_RATE_50M;
            end else if (modeBus.strapValid) begin
                mode_q[i] <= modeBus.strapMode;
                bcRate_q[i] <= bc_default(modeBus.strapMode);
            end else if (wrStrobe && wrMask[i]) begin
                if (regPtr_q == OFS_RX_MODE) begin
                    mode_q[i] <= shift_q[1:0];
                    bcRate_q[i] <= bc_default(shift_q[1:0]);
                end else if (regPtr_q == OFS_BC_RATE) begin
                    bcRate_q[i] <= shift_q[2:0];
                end
            end
        end

        always_ff @(posedge sys_clk or negedge nrst) begin
            if (!nrst) begin
                frame_q[i] <= FRAME_BITS_CSI2;
            end else begin
                frame_q[i] <= frame_bits(mode_q[i]);
            end
        end

        assign rxModeOut[2*i+:2] = mode_q[i];
        assign bcRateOut[3*i+:3] = bcRate_q[i];
        assign frameBitsOut[6*i+:6] = frame_q[i];
    end

    // Backup oscillator until the reference is seen steadily; fall back on a long gap
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            useRef_q <= 1'b0;
            refCnt_q <= 12'h000;
        end else if (useRef_q == refSync_q) begin
            refCnt_q <= 12'h000;
        end else if (refCnt_q == (useRef_q ? GAP_CNT : QUAL_CNT)) begin
            useRef_q <= refSync_q;
            refCnt_q <= 12'h000;
        end else begin
            refCnt_q <= refCnt_q + 12'h001;
        end
    end

    assign useRefClk = useRef_q;
    assign backupOscOn = ~useRef_q;
    assign rxPortDisable = rxDisable_q;
    assign forwardEnable = fwdCtl_q;
    assign sdaOe = sdaOe_q;
    assign sdaOut = 1'b0;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);

    property p_mode_source;
        modeBus.strapValid |=> mode_q[0] == $past(modeBus.strapMode);
    endproperty
    a_mode_source: assert property (p_mode_source) else $error("strap not loaded");

    property p_csi_defaults;
        modeBus.strapValid && modeBus.strapMode == MODE_CSI2
        |=> bcRate_q[1] == BC_RATE_50M ##1 frame_q[1] == FRAME_BITS_CSI2;
    endproperty
    a_csi_defaults: assert property (p_csi_defaults) else $error("bad CSI-2 defaults");

    property p_bc_select;
        wrStrobe && regPtr_q == OFS_BC_RATE && wrMask[2] && shift_q[2:0] == BC_RATE_10M
        |=> bcRate_q[2] == BC_RATE_10M;
    endproperty
    a_bc_select: assert property (p_bc_select) else $error("rate write lost");

    property p_raw_defaults;
        modeBus.strapValid && modeBus.strapMode != MODE_CSI2
        |=> bcRate_q[3] == BC_RATE_2M5 ##1 frame_q[3] == FRAME_BITS_RAW;
    endproperty
    a_raw_defaults: assert property (p_raw_defaults) else $error("bad RAW defaults");

    property p_port_ctl;
        wrStrobe && regPtr_q == OFS_RX_DISABLE && !remote_q
        |=> rxPortDisable == $past(shift_q[NUM_PORTS-1:0]);
    endproperty
    a_port_ctl: assert property (p_port_ctl) else $error("disable write lost");

    property p_remote_blocked;
        wrStrobe && regPtr_q == OFS_RX_DISABLE && remote_q |=> $stable(rxPortDisable);
    endproperty
    a_remote_blocked: assert property (p_remote_blocked) else $error("remote wrote disable");

    property p_page_gate;
        wrStrobe && regPtr_q == OFS_RX_MODE && !wrMask[3] && !modeBus.strapValid |=> $stable(mode_q[3]);
    endproperty
    a_page_gate: assert property (p_page_gate) else $error("unpaged port written");

    property p_remote_page;
        wrStrobe && remote_q && !direct_q && regPtr_q == OFS_RX_MODE && !modeBus.strapValid
        |=> mode_q[remPort_q] == $past(shift_q[1:0]);
    endproperty
    a_remote_page: assert property (p_remote_page) else $error("remote page wrong");

    property p_direct_ack;
        state_q == ST_ADDR_DONE && sclFall && !startDet && !stopDet && |portHit && !hostHit
        |=> sdaOe_q && direct_q && state_q == ST_ACK;
    endproperty
    a_direct_ack: assert property (p_direct_ack) else $error("direct address not acked");

    property p_shared_direct;
        wrStrobe && direct_q && regPtr_q == OFS_FWD_CTL |=> forwardEnable == $past(shift_q[NUM_PORTS-1:0]);
    endproperty
    a_shared_direct: assert property (p_shared_direct) else $error("shared write lost");

    property p_fwd_hold;
        !(wrStrobe && regPtr_q == OFS_FWD_CTL) |=> $stable(forwardEnable);
    endproperty
    a_fwd_hold: assert property (p_fwd_hold) else $error("forwarding changed unasked");

    property p_ref_fallback;
        useRef_q && !refSync_q && refCnt_q == GAP_CNT |=> !useRefClk && backupOscOn;
    endproperty
    a_ref_fallback: assert property (p_ref_fallback) else $error("no fallback on gap");

    property p_ref_qualify;
        $rose(useRef_q) |-> $past(refCnt_q) == QUAL_CNT && $past(refSync_q);
    endproperty
    a_ref_qualify: assert property (p_ref_qualify) else $error("reference taken early");

    c_write: cover property (wrStrobe && regPtr_q == OFS_RX_MODE);
    c_read: cover property (state_q == ST_RDATA && sclRise);
    c_direct: cover property (state_q == ST_ACK && direct_q);
    c_ref: cover property ($rose(useRef_q));
endmodule
`default_nettype wire

// *** dv/i2c_host_model.sv ***
// Local I2C master model for the hub's target pins
`default_nettype none
module i2c_host_model (
    // Clock
    input wire logic sys_clk,
    // Bus
    input wire logic sdaIn,
    output logic scl,
    output logic sdaPull
);
    timeunit 1ns;
    timeprecision 1ps;
    logic ack;
    initial begin
        scl = 1'b1;
        sdaPull = 1'b0;
    end
    task automatic hold();
        repeat (4) @(posedge sys_clk);
        #1;
    endtask
    // Data moves only in the middle of SCL low, never at its edges
    task automatic bit_x(input logic b, output logic r);
        hold();
        sdaPull = ~b;
        hold();
        scl = 1'b1;
        hold();
        r = sdaIn;
        scl = 1'b0;
    endtask
    task automatic start();
        sdaPull = 1'b0;
        hold();
        scl = 1'b1;
        hold();
        sdaPull = 1'b1;
        hold();
        scl = 1'b0;
    endtask
    task automatic stop();
        hold();
        sdaPull = 1'b1;
        hold();
        scl = 1'b1;
        hold();
        sdaPull = 1'b0;
        hold();
    endtask
    task automatic byte_x(input logic [7:0] d, input logic m, output logic [7:0] q);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], r);
            q[i] = r;
        end
        bit_x(m, ack);
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] o, input logic [7:0] d);
        logic [7:0] q;
        start();
        byte_x({a, 1'b0}, 1'b1, q);
        byte_x(o, 1'b1, q);
        byte_x(d, 1'b1, q);
        stop();
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] o, output logic [7:0] d);
        logic [7:0] q;
        start();
        byte_x({a, 1'b0}, 1'b1, q);
        byte_x(o, 1'b1, q);
        start();
        byte_x({a, 1'b1}, 1'b1, q);
        byte_x(8'hFF, 1'b1, d);
        stop();
    endtask
endmodule
`default_nettype wire

// *** dv/tb_hub_rx_port_config.sv ***
// Self-checking bench for the receive-port configuration hub
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_total++; \
    $display("ERROR t=%0t got %0h exp %0h", $time, a, b); end end
module tb_hub_rx_port_config;
    timeunit 1ns;
    timeprecision 1ps;
    import hub_cfg_pkg::*;
    logic sys_clk = 1'b0, nrst = 1'b0, remoteAccess = 1'b0, refClkPresent = 1'b0;
    logic scl, sdaPull, sdaOut, sdaOe, useRefClk, backupOscOn;
    logic [1:0] remotePort = 2'h0;
    logic [2:0] modeStrapIdx;
    logic [3:0] rxPortDisable, forwardEnable;
    logic [7:0] rxModeOut, d, v;
    logic [11:0] bcRateOut;
    logic [23:0] frameBitsOut;
    int err_total = 0, compares = 0, n;
    wire logic sda = ~sdaPull & (sdaOe ? sdaOut : 1'b1);
    always #20 sys_clk = ~sys_clk;
    i2c_host_model i_i2c_host_model (.sys_clk(sys_clk), .sdaIn(sda), .scl(scl), .sdaPull(sdaPull));
    hub_rx_port_config i_hub_rx_port_config (.sys_clk(sys_clk), .nrst(nrst), .sclIn(scl), .sdaIn(sda),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .remoteAccess(remoteAccess), .remotePort(remotePort),
        .modeStrapIdx(modeStrapIdx), .refClkPresent(refClkPresent), .rxPortDisable(rxPortDisable),
        .forwardEnable(forwardEnable), .rxModeOut(rxModeOut), .bcRateOut(bcRateOut),
        .frameBitsOut(frameBitsOut), .useRefClk(useRefClk), .backupOscOn(backupOscOn));
    task automatic wr(input logic [6:0] a, input logic [7:0] o, input logic [7:0] x);
        i_i2c_host_model.wr(a, o, x);
    endtask
    // Port i mode in mv[2i+1:2i]; back-channel and frame width follow the mode
    task automatic chk_mode(input logic [7:0] mv);
        for (int i = 0; i < 4; i++) begin
            `CHK(rxModeOut[2*i+:2], mv[2*i+:2])
            `CHK(bcRateOut[3*i+:3], (mv[2*i+:2] == 2'h0) ? 3'h6 : 3'h0)
            `CHK(frameBitsOut[6*i+:6], (mv[2*i+:2] == 2'h0) ? 6'h28 : 6'h1C)
        end
    endtask
    task automatic end_of_test();
        $display("compares=%0d err_total=%0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        void'($urandom(32'hB623));
        modeStrapIdx = 3'($urandom_range(7, 0));
        repeat (20) @(posedge sys_clk);
        #1 nrst = 1'b1;
        repeat (10) @(posedge sys_clk);
        #1;
        `CHK(forwardEnable, 4'h0)
        `CHK({useRefClk, backupOscOn}, 2'b01)
        chk_mode({4{modeStrapIdx[1:0]}});
        i_i2c_host_model.rd(DEV_ADDR_DEFAULT, 8'h4C, d);
        `CHK(d, 8'h01)
        $display("test reset done");
        v = 8'($urandom);
        wr(DEV_ADDR_DEFAULT, 8'h20, v);
        `CHK(forwardEnable, v[3:0])
        wr(DEV_ADDR_DEFAULT, 8'h0C, ~v);
        `CHK(rxPortDisable, ~v[3:0])
        remoteAccess = 1'b1;
        wr(DEV_ADDR_DEFAULT, 8'h0C, v);
        `CHK(rxPortDisable, ~v[3:0])
        remoteAccess = 1'b0;
        $display("test enables done");
        wr(DEV_ADDR_DEFAULT, 8'h4C, 8'h0F);
        for (int m = 0; m < 4; m++) begin
            wr(DEV_ADDR_DEFAULT, 8'h6D, 8'(m));
            chk_mode({4{2'(m)}});
            i_i2c_host_model.rd(DEV_ADDR_DEFAULT, 8'h6D, d);
            `CHK(d[1:0], 2'(m))
        end
        wr(DEV_ADDR_DEFAULT, 8'h58, 8'h02);
        `CHK(bcRateOut, {4{3'h2}})
        $display("test modes done");
        wr(DEV_ADDR_DEFAULT, 8'h6D, 8'h00);
        wr(DEV_ADDR_DEFAULT, 8'hF9, {7'h50, 1'b1});
        wr(7'h50, 8'h6D, 8'h01);
        wr(7'h50, 8'h20, ~v);
        `CHK(forwardEnable, ~v[3:0])
        remoteAccess = 1'b1;
        remotePort = 2'h2;
        wr(DEV_ADDR_DEFAULT, 8'h6D, 8'h02);
        remoteAccess = 1'b0;
        chk_mode(8'b00_10_01_00);
        i_i2c_host_model.rd(DEV_ADDR_DEFAULT, 8'h30, d);
        `CHK(d, 8'h00)
        $display("test paging done");
        refClkPresent = 1'b1;
        n = 0;
        while (useRefClk !== 1'b1 && n < 400) begin
            @(posedge sys_clk);
            #1 n++;
        end
        `CHK((n >= 250 && n <= 256), 1'b1)
        `CHK(backupOscOn, 1'b0)
        $display("test reference_clock_in done");
        // Losing the reference for the gap time must fall back to the backup oscillator
        refClkPresent = 1'b0;
        n = 0;
        while (useRefClk !== 1'b0 && n < 700) begin
            @(posedge sys_clk);
            #1 n++;
        end
        `CHK((n >= 500 && n <= 506), 1'b1)
        `CHK(backupOscOn, 1'b1)
        $display("test fallback done");
        end_of_test();
    end
endmodule
`default_nettype wire
